//--- src/fep_afifo.sv
// dual-clock fifo with gray-coded pointers
`timescale 1ns/10ps
module fep_afifo
   import fep_pkg::*;
#(
   parameter int W = 6,
   parameter int DEPTH = FEP_FIFO_DEPTH
) (
   input wire logic wclk,
   input wire logic wrst_b,
   input wire logic w_valid,
   output logic w_ready,
   input wire logic [W-1:0] w_data,
   input wire logic rclk,
   input wire logic rrst_b,
   output logic r_valid,
   input wire logic r_ready,
   output logic [W-1:0] r_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wbin, wgray, rbin, rgray;
   logic [AW:0] rg_meta, rg_sync, wg_meta, wg_sync;

   // next pointers and gray codes
   wire w_do = w_valid & w_ready;
   wire r_do = r_valid & r_ready;
   wire [AW:0] next_wbin = wbin + (AW+1)'(w_do);
   wire [AW:0] next_wgray = next_wbin ^ (next_wbin >> 1);
   wire [AW:0] next_rbin = rbin + (AW+1)'(r_do);
   wire [AW:0] next_rgray = next_rbin ^ (next_rbin >> 1);

   // full when write gray equals read gray with top two bits inverted
   assign w_ready = (wgray != {~rg_sync[AW:AW-1], rg_sync[AW-2:0]});
   assign r_valid = (rgray != wg_sync);
   assign r_data = mem[rbin[AW-1:0]];

   // write side pointer and storage
   always_ff @(posedge wclk) begin
      if (!wrst_b) begin
         wbin <= '0;
         wgray <= '0;
      end else begin
         wbin <= next_wbin;
         wgray <= next_wgray;
      end
   end

   always_ff @(posedge wclk) begin
      if (w_do) begin
         mem[wbin[AW-1:0]] <= w_data;
      end
   end

   // read pointer brought into the write domain
   always_ff @(posedge wclk) begin
      if (!wrst_b) begin
         rg_meta <= '0;
         rg_sync <= '0;
      end else begin
         rg_meta <= rgray;
         rg_sync <= rg_meta;
      end
   end

   // read side pointer
   always_ff @(posedge rclk) begin
      if (!rrst_b) begin
         rbin <= '0;
         rgray <= '0;
      end else begin
         rbin <= next_rbin;
         rgray <= next_rgray;
      end
   end

   // write pointer brought into the read domain
   always_ff @(posedge rclk) begin
      if (!rrst_b) begin
         wg_meta <= '0;
         wg_sync <= '0;
      end else begin
         wg_meta <= wgray;
         wg_sync <= wg_meta;
      end
   end

endmodule : fep_afifo

//--- src/fep_pcs.sv
// 100 Mbps coding sublayer: mii on mclk, code groups on the link clock
`timescale 1ns/10ps

// Notes on behaviour
// - the link carries five-bit code groups, one nibble or control code each
// - with transmit enable low, idle groups go to the line once T and R have been sent
// - idle is all ones and carries no nibble
// - first two nibbles of a frame are replaced by J then K
// - every later nibble is encoded until transmit enable drops
// - nibbles map to groups by the fixed table; decoding inverts it
// - frame end sends T then R, then idle again
// - received J and K become two preamble nibbles on receive data
// - the whole preamble is passed to the mac, none dropped
// - transmit groups are scrambled, received groups descrambled before decoding
// - an invalid received group inside a frame raises receive error; between frames it is ignored
// - collision output stays high as long as the collision lasts
// - with an invalid group the receive data shows 0101
// - receive data valid spans the first preamble nibble to the last nibble
// - both mii clocks run at 25 MHz
module fep_pcs
   import fep_pkg::*;
#(
   parameter int DEPTH = FEP_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic lclk,
   output logic tx_clk,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   output logic rx_clk,
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic rx_er,
   output logic crs,
   output logic col,
   input wire logic half_duplex,
   output logic [4:0] tx_sym,
   input wire logic [4:0] rx_sym
);
   typedef enum logic [1:0] {
      FEP_TX_IDLE = 2'b00,
      FEP_TX_K = 2'b01,
      FEP_TX_DATA = 2'b10,
      FEP_TX_R = 2'b11
   } fep_tx_state_t;

   typedef enum logic [1:0] {
      FEP_RX_HUNT = 2'b00,
      FEP_RX_K = 2'b01,
      FEP_RX_DATA = 2'b10,
      FEP_RX_R = 2'b11
   } fep_rx_state_t;

   // ---------------- mclk domain ----------------
   logic [3:0] div_cnt;
   fep_mii_tx_t tx_meta, tx_sync;
   logic hd_meta, hd_sync;
   logic act_meta, act_sync;
   fep_tx_state_t tx_state, next_tx_state;
   logic enq_valid;
   logic [4:0] enq_sym;
   logic [4:0] next_enq_sym;
   logic next_enq;
   logic rx_closing;
   logic enq_ready;
   logic rxq_valid;
   fep_rxw_t rxq_word;

   // ---------------- lclk domain ----------------
   logic lrst_meta, lrst_b;
   logic txq_valid;
   logic [4:0] txq_sym;
   logic [4:0] line_plain;
   logic [4:0] rx_line;
   logic [4:0] rx_plain;
   fep_rx_state_t rx_state, next_rx_state;
   logic push_ok;
   logic next_push;
   fep_rxw_t next_word;
   logic rx_active;

   // mii clock divider: one toggle every half period
   wire div_wrap = (div_cnt == 4'(FEP_MII_HALF_CYC - 1));
   wire mii_fall = div_wrap & tx_clk;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         div_cnt <= '0;
         tx_clk <= 1'b0;
         rx_clk <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
         tx_clk <= div_wrap ? ~tx_clk : tx_clk;
         rx_clk <= div_wrap ? ~rx_clk : rx_clk;
      end
   end

   // pins and the link-side carrier level through two flops
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tx_meta <= '0;
         tx_sync <= '0;
         hd_meta <= 1'b0;
         hd_sync <= 1'b0;
         act_meta <= 1'b0;
         act_sync <= 1'b0;
      end else begin
         tx_meta <= '{en: tx_en, d: txd};
         tx_sync <= tx_meta;
         hd_meta <= half_duplex;
         hd_sync <= hd_meta;
         act_meta <= rx_active;
         act_sync <= act_meta;
      end
   end

   // transmit framing, one decision per mii clock, taken at its falling edge
   always_comb begin
      next_tx_state = tx_state;
      next_enq = 1'b0;
      next_enq_sym = FEP_SYM_IDLE;
      if (mii_fall) begin
         case (tx_state)
            FEP_TX_IDLE: begin
               if (tx_sync.en) begin
                  next_enq = 1'b1;
                  next_enq_sym = FEP_SYM_J;
                  next_tx_state = FEP_TX_K;
               end
            end
            FEP_TX_K: begin
               next_enq = 1'b1;
               next_enq_sym = tx_sync.en ? FEP_SYM_K : FEP_SYM_T;
               next_tx_state = tx_sync.en ? FEP_TX_DATA : FEP_TX_R;
            end
            FEP_TX_DATA: begin
               next_enq = 1'b1;
               next_enq_sym = tx_sync.en ? FEP_ENC[tx_sync.d] : FEP_SYM_T;
               next_tx_state = tx_sync.en ? FEP_TX_DATA : FEP_TX_R;
            end
            FEP_TX_R: begin
               next_enq = 1'b1;
               next_enq_sym = FEP_SYM_R;
               next_tx_state = FEP_TX_IDLE;
            end
            default: begin
               next_tx_state = FEP_TX_IDLE;
            end
         endcase
      end
   end

   // one-cycle write into the transmit fifo; dropped if it is full
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tx_state <= FEP_TX_IDLE;
         enq_valid <= 1'b0;
         enq_sym <= FEP_SYM_IDLE;
      end else begin
         tx_state <= next_tx_state;
         enq_valid <= next_enq;
         enq_sym <= next_enq_sym;
      end
   end

   // transmit code groups cross to the link clock
   fep_afifo #(.W(5), .DEPTH(DEPTH)) u_txq (
      .wclk(mclk),
      .wrst_b(rst_b),
      .w_valid(enq_valid),
      .w_ready(enq_ready),
      .w_data(enq_sym),
      .rclk(lclk),
      .rrst_b(lrst_b),
      .r_valid(txq_valid),
      .r_ready(1'b1),
      .r_data(txq_sym)
   );

   // receive words presented at the falling edge so the mac samples them on the rise
   wire rx_slot = mii_fall;
   wire rxq_pop = rx_slot & rxq_valid & ~rx_closing;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rxd <= 4'h0;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
         rx_closing <= 1'b0;
      end else if (rx_slot) begin
         if (rx_closing) begin
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= 4'h0;
            rx_closing <= 1'b0;
         end else if (rxq_valid && rxq_word.last && !rxq_word.err) begin
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= 4'h0;
         end else if (rxq_valid) begin
            rx_dv <= 1'b1;
            rx_er <= rxq_word.err;
            rxd <= rxq_word.nib;
            rx_closing <= rxq_word.last;
         end else if (rx_dv) begin
            rx_er <= 1'b1; // underrun inside a frame
            rxd <= FEP_NIB_ERR;
         end
      end
   end

   // carrier and collision from the transmit and receive activity
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         crs <= 1'b0;
         col <= 1'b0;
      end else begin
         crs <= act_sync | (hd_sync & tx_sync.en);
         col <= hd_sync & tx_sync.en & act_sync;
      end
   end

   // ---------------- link clock logic ----------------

   // reset brought into the link domain
   always_ff @(posedge lclk) begin
      lrst_meta <= rst_b;
      lrst_b <= lrst_meta;
   end

   // empty fifo means idle fill between frames
   assign line_plain = txq_valid ? txq_sym : FEP_SYM_IDLE;

   fep_scram #(.DESCR(1'b0)) u_scr (
      .clk(lclk),
      .rst_b(lrst_b),
      .in_sym(line_plain),
      .out_sym(tx_sym)
   );

   // line symbols are in the link clock's own domain: one capture stage
   always_ff @(posedge lclk) begin
      if (!lrst_b) begin
         rx_line <= FEP_SYM_IDLE;
      end else begin
         rx_line <= rx_sym;
      end
   end

   fep_scram #(.DESCR(1'b1)) u_dscr (
      .clk(lclk),
      .rst_b(lrst_b),
      .in_sym(rx_line),
      .out_sym(rx_plain)
   );

   // receive framing on descrambled groups
   wire [4:0] dec = fep_decode(rx_plain);

   always_comb begin
      next_rx_state = rx_state;
      next_push = 1'b0;
      next_word = '{last: 1'b0, err: 1'b0, nib: FEP_NIB_PRE};
      case (rx_state)
         FEP_RX_HUNT: begin
            if (rx_plain == FEP_SYM_J) begin
               next_push = 1'b1;
               next_rx_state = FEP_RX_K;
            end
         end
         FEP_RX_K: begin
            next_push = 1'b1;
            if (rx_plain == FEP_SYM_K) begin
               next_rx_state = FEP_RX_DATA;
            end else begin
               next_word = '{last: 1'b1, err: 1'b1, nib: FEP_NIB_ERR};
               next_rx_state = FEP_RX_HUNT;
            end
         end
         FEP_RX_DATA: begin
            if (rx_plain == FEP_SYM_T) begin
               next_rx_state = FEP_RX_R;
            end else if (rx_plain == FEP_SYM_IDLE) begin
               next_push = 1'b1;
               next_word = '{last: 1'b1, err: 1'b1, nib: FEP_NIB_ERR};
               next_rx_state = FEP_RX_HUNT;
            end else begin
               next_push = 1'b1;
               next_word = '{last: 1'b0, err: ~dec[4], nib: dec[3:0]};
            end
         end
         FEP_RX_R: begin
            next_push = 1'b1;
            next_word = '{last: 1'b1, err: (rx_plain != FEP_SYM_R), nib: FEP_NIB_ERR};
            next_rx_state = FEP_RX_HUNT;
         end
         default: begin
            next_rx_state = FEP_RX_HUNT;
         end
      endcase
   end

   always_ff @(posedge lclk) begin
      if (!lrst_b) begin
         rx_state <= FEP_RX_HUNT;
         rx_active <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         rx_active <= (next_rx_state != FEP_RX_HUNT);
      end
   end

   // receive words cross back to mclk; a full fifo drops the word
   fep_afifo #(.W($bits(fep_rxw_t)), .DEPTH(DEPTH)) u_rxq (
      .wclk(lclk),
      .wrst_b(lrst_b),
      .w_valid(next_push),
      .w_ready(push_ok),
      .w_data(next_word),
      .rclk(mclk),
      .rrst_b(rst_b),
      .r_valid(rxq_valid),
      .r_ready(rxq_pop),
      .r_data(rxq_word)
   );

endmodule : fep_pcs

//--- src/fep_pkg.sv
// shared constants, types and code tables of the 100 Mbps coding sublayer
package fep_pkg;

   // five-bit code groups
   localparam logic [4:0] FEP_SYM_IDLE = 5'h1f;
   localparam logic [4:0] FEP_SYM_J = 5'h18;
   localparam logic [4:0] FEP_SYM_K = 5'h11;
   localparam logic [4:0] FEP_SYM_T = 5'h0d;
   localparam logic [4:0] FEP_SYM_R = 5'h07;

   // nibble values put on the receive data
   localparam logic [3:0] FEP_NIB_PRE = 4'h5;
   localparam logic [3:0] FEP_NIB_ERR = 4'h5;

   // data nibble to code group, indexed by nibble
   localparam logic [4:0] FEP_ENC [16] = '{
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

   // timing
   localparam int FEP_MCLK_PERIOD_NS = 4;
   localparam int FEP_MII_PERIOD_NS = 40;
   localparam int FEP_MII_HALF_CYC = FEP_MII_PERIOD_NS / (2 * FEP_MCLK_PERIOD_NS);

   // scrambler polynomial taps and start state
   localparam int FEP_SCR_TAP_A = 10;
   localparam int FEP_SCR_TAP_B = 8;
   localparam logic [10:0] FEP_SCR_SEED = 11'h000;

   localparam int FEP_FIFO_DEPTH = 16;

   // word that crosses from the link receiver to the mii side
   typedef struct packed {
      logic last;
      logic err;
      logic [3:0] nib;
   } fep_rxw_t;

   // sampled mii transmit inputs
   typedef struct packed {
      logic en;
      logic [3:0] d;
   } fep_mii_tx_t;

   // code group to {valid, nibble}; only the sixteen data groups are valid
   function automatic logic [4:0] fep_decode(input logic [4:0] sym);
      logic [4:0] res;
      res = {1'b0, FEP_NIB_ERR};
      for (int n = 0; n < 16; n++) begin
         if (FEP_ENC[n] == sym) begin
            res = {1'b1, 4'(n)};
         end
      end
      return res;
   endfunction : fep_decode

endpackage : fep_pkg

//--- src/fep_scram.sv
// self-synchronising scrambler or descrambler, five bits a clock, msb first
`timescale 1ns/10ps
module fep_scram
   import fep_pkg::*;
#(
   parameter bit DESCR = 1'b0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] in_sym,
   output logic [4:0] out_sym
);
   logic [10:0] lfsr;
   logic [10:0] next_lfsr;
   logic [4:0] next_out;

   // step the shift register once per bit; the descrambler shifts line bits
   always_comb begin
      next_lfsr = lfsr;
      next_out = '0;
      for (int i = 4; i >= 0; i--) begin
         next_out[i] = in_sym[i] ^ next_lfsr[FEP_SCR_TAP_A] ^ next_lfsr[FEP_SCR_TAP_B];
         next_lfsr = {next_lfsr[9:0], (DESCR ? in_sym[i] : next_out[i])};
      end
   end

   // registered result
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lfsr <= FEP_SCR_SEED;
         out_sym <= '0;
      end else begin
         lfsr <= next_lfsr;
         out_sym <= next_out;
      end
   end

endmodule : fep_scram

//--- testbench/fep_mac.sv
// mii mac model: sends frames, collects receive nibbles with their error flag
`timescale 1ns/10ps
module fep_mac
   import fep_pkg::*;
(
   input wire logic mclk,
   input wire logic tx_clk,
   input wire logic rx_clk,
   output logic tx_en,
   output logic [3:0] txd,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er
);
   logic [4:0] rx_q[$];
   int frames = 0;
   logic dv_d = 1'b0;
   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
   end
   // one nibble per tx clock, changed just after its rising edge
   task automatic send(input logic [3:0] nib[$]);
      foreach (nib[i]) begin
         @(posedge tx_clk);
         @(negedge mclk);
         tx_en = 1'b1;
         txd = nib[i];
      end
      @(posedge tx_clk);
      @(negedge mclk);
      tx_en = 1'b0;
      txd = ~txd;
   endtask : send
   // nibbles taken on the rx clock rise while the frame is valid
   always @(posedge rx_clk) begin
      if (rx_dv === 1'b1) rx_q.push_back({rx_er, rxd});
      if (dv_d === 1'b1 && rx_dv === 1'b0) frames++;
      dv_d = rx_dv;
   end
endmodule : fep_mac

//--- testbench/fep_pcs_bench.sv
// self-checking bench of the coding sublayer, link side driven here
`timescale 1ns/10ps
module fep_pcs_bench
   import fep_pkg::*;
;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst_b = 1'b0;
   logic half_duplex = 1'b0;
   logic [4:0] rx_sym = 5'h00;
   logic [10:0] dsh = 11'h000;
   logic [10:0] ssh = 11'h000;
   logic [4:0] tx_q[$];
   logic [4:0] rx_src[$];
   logic col_seen = 1'b0;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   wire tx_clk, rx_clk, tx_en, rx_dv, rx_er, crs, col;
   wire [3:0] txd, rxd;
   wire [4:0] tx_sym;
   always #2 mclk = ~mclk;
   always #62.5 lclk = ~lclk;
   fep_pcs u_fep_pcs (.mclk(mclk), .rst_b(rst_b), .lclk(lclk), .tx_clk(tx_clk), .tx_en(tx_en),
      .txd(txd), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
      .col(col), .half_duplex(half_duplex), .tx_sym(tx_sym), .rx_sym(rx_sym));
   fep_mac u_fep_mac (.mclk(mclk), .tx_clk(tx_clk), .rx_clk(rx_clk), .tx_en(tx_en),
      .txd(txd), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er));
   // descramble the line, bit 4 first, one group per link clock
   always @(negedge lclk) begin : tx_mon
      logic [4:0] d;
      for (int b = 4; b >= 0; b--) begin
         d[b] = tx_sym[b] ^ dsh[FEP_SCR_TAP_A] ^ dsh[FEP_SCR_TAP_B];
         dsh = {dsh[9:0], tx_sym[b]};
      end
      if (rst_b) tx_q.push_back(d);
   end
   // scramble queued groups onto the line, idle when nothing queued
   always @(negedge lclk) begin : rx_drv
      logic [4:0] s;
      logic [4:0] o;
      s = (rx_src.size() > 0) ? rx_src.pop_front() : 5'h1f;
      for (int b = 4; b >= 0; b--) begin
         o[b] = s[b] ^ ssh[FEP_SCR_TAP_A] ^ ssh[FEP_SCR_TAP_B];
         ssh = {ssh[9:0], o[b]};
      end
      rx_sym = o;
   end
   // hang guard and collision watch
   always @(posedge mclk) begin
      cyc++;
      if (col === 1'b1) col_seen = 1'b1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic check(input bit ok, input string msg);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // frame out: idle, J K, coded nibbles, T R, idle again
   task automatic test_tx;
      int i;
      logic [4:0] exp[$];
      i = 0;
      exp = '{5'h18, 5'h11, 5'h0b, 5'h1b, 5'h1e, 5'h09, 5'h16, 5'h1d, 5'h0d, 5'h07, 5'h1f};
      tx_q.delete();
      repeat (3) @(posedge lclk);
      u_fep_mac.send('{4'h5, 4'h5, 4'h5, 4'hd, 4'h0, 4'h1, 4'ha, 4'hf});
      repeat (20) @(posedge lclk);
      while (tx_q.size() > 0 && tx_q[0] === 5'h1f) begin
         i++;
         void'(tx_q.pop_front());
      end
      check(i > 0, "no idle fill before frame");
      foreach (exp[k])
         check(tx_q.size() > k && tx_q[k] === exp[k], "tx sym");
      check(!col_seen, "collision in full duplex");
   endtask : test_tx
   // frame in: valid nibbles in order, errors flagged, frame closed once
   task automatic test_rx(input logic [4:0] grp[$], input logic [3:0] exp[$], input bit bad);
      logic [4:0] q[$];
      logic [4:0] w;
      int f0;
      int errs;
      errs = 0;
      u_fep_mac.rx_q.delete();
      f0 = u_fep_mac.frames;
      rx_src = grp;
      repeat (grp.size() + 12) @(posedge lclk);
      q = u_fep_mac.rx_q;
      while (q.size() > 0) begin
         w = q.pop_front();
         if (w[4]) errs++;
         else begin
            check(exp.size() > 0 && w[3:0] === exp[0], "rx nibble");
            if (exp.size() > 0) void'(exp.pop_front());
         end
      end
      check(exp.size() == 0, "rx nibbles missing");
      check(u_fep_mac.frames == f0 + 1, "rx frame not closed");
      if (bad) check(errs > 0, "no rx error");
   endtask : test_rx
   // transmit during receive in half duplex raises col, which then clears
   task automatic test_col;
      col_seen = 1'b0;
      @(negedge mclk);
      half_duplex = 1'b1;
      rx_src = '{5'h18, 5'h11};
      repeat (12) rx_src.push_back(5'h0b);
      rx_src.push_back(5'h0d);
      rx_src.push_back(5'h07);
      repeat (4) @(posedge lclk);
      u_fep_mac.send('{4'h5, 4'h5, 4'h5, 4'hd});
      repeat (30) @(posedge lclk);
      check(col_seen, "no collision");
      check(col === 1'b0, "collision held after end");
      @(negedge mclk);
      half_duplex = 1'b0;
   endtask : test_col
   initial begin
      repeat (12) @(posedge lclk);
      @(negedge mclk);
      rst_b = 1'b1;
      repeat (20) @(posedge lclk);
      test_tx();
      test_rx('{5'h18, 5'h11, 5'h0b, 5'h1b, 5'h16, 5'h1d, 5'h0d, 5'h07},
         '{4'h5, 4'h5, 4'h5, 4'hd, 4'ha, 4'hf}, 1'b0);
      test_rx('{5'h18, 5'h11, 5'h0b, 5'h00, 5'h1d, 5'h0d, 5'h07},
         '{4'h5, 4'h5, 4'h5, 4'hf}, 1'b1);
      test_col();
      stop_test();
   end
endmodule : fep_pcs_bench

//--- testbench/fep_pcs_chk.sv
// concurrent checks on the mii side of the coding sublayer
`timescale 1ns/10ps
module fep_pcs_chk
   import fep_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tx_clk,
   input wire logic tx_en,
   input wire logic rx_clk,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic crs,
   input wire logic col,
   input wire logic half_duplex
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [3:0] hd_low;
   logic [3:0] tx_low;
   // cycles since half duplex or transmit enable was last high, saturating
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hd_low <= 4'h0;
         tx_low <= 4'h0;
      end else begin
         hd_low <= half_duplex ? 4'h0 : hd_low + {3'h0, hd_low != 4'hf};
         tx_low <= tx_en ? 4'h0 : tx_low + {3'h0, tx_low != 4'hf};
      end
   end
   a_col_half_only: assert property (hd_low > 4'h8 |-> !col)
      else $error("col in full duplex");
   a_col_tx_only: assert property (tx_low > 4'h8 |-> !col)
      else $error("col without transmit");
   a_col_with_crs: assert property (col |-> crs)
      else $error("col without carrier");
   a_err_nibble: assert property (rx_er |-> rxd == FEP_NIB_ERR)
      else $error("bad error nibble");
   a_err_in_frame: assert property (rx_er |-> rx_dv)
      else $error("error outside frame");
   a_clk_half_period: assert property (
      $changed(tx_clk) |=> $stable(tx_clk)[*4] ##1 $changed(tx_clk))
      else $error("tx clock not 25 MHz");
   a_clk_same_phase: assert property (rx_clk == tx_clk)
      else $error("mii clocks apart");
   a_rx_on_fall: assert property ($changed({rxd, rx_dv, rx_er}) |-> $fell(rx_clk))
      else $error("receive outputs off slot");
   // main scenarios reached
   c_col: cover property (col);
   c_frame: cover property ($rose(rx_dv));
   c_err: cover property (rx_er);
endmodule : fep_pcs_chk

bind fep_pcs fep_pcs_chk u_fep_pcs_chk (.mclk(mclk), .rst_b(rst_b), .tx_clk(tx_clk),
   .tx_en(tx_en), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
   .col(col), .half_duplex(half_duplex));
